/* verilog/tcc_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tcc_cfg.svh"
module tcc_top (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	// Mode and count clock
	input  wire logic        OP_MODE_BIT_LO,
	input  wire logic        OP_MODE_BIT_HI,
	input  wire logic        COUNT_TICK,
	// Register b setup
	input  wire logic        CAPCOMP_B_CAPTURE,
	input  wire logic        CAPCOMP_B_WR,
	input  wire logic [15:0] CAPCOMP_B_WDATA,
	input  wire logic        CAPCOMP_B_RD,
	// Register a setup
	input  wire logic        CAPCOMP_A_CAPTURE,
	input  wire logic        CAPCOMP_A_WR,
	input  wire logic [15:0] CAPCOMP_A_WDATA,
	input  wire logic        CAPCOMP_A_RD,
	// Counter read
	input  wire logic        COUNTER_RD,
	// Pins
	input  wire logic        EDGE_INPUT_A,
	input  wire logic        SHARED_PORT_PIN_IN,
	input  wire logic        PIN_SEL_OUTPUT,
	output logic             SHARED_PORT_PIN_OUT,
	output logic             SHARED_PORT_PIN_OE,
	// Results
	output logic [15:0]      UP_COUNTER,
	output logic [15:0]      COUNTER_RDATA,
	output logic [15:0]      CAPCOMP_A_RDATA,
	output logic [15:0]      CAPCOMP_B_RDATA,
	output logic             MATCH_IRQ_A,
	output logic             MATCH_IRQ_B
);
	tcc_pkg::run_state_t st_q, st_d;
	logic [15:0] up_counter_q, up_counter_d;
	logic [15:0] cnt_rd_q, cnt_rd_d;
	logic        timer_out_q, timer_out_d;
	logic        irq_a_q, irq_a_d, irq_b_q, irq_b_d;
	logic        oe_q, oe_d;
	logic        pin_out_q, pin_out_d;
	logic        ein_a_q, ein_b_q, ein_b_d;
	logic        edge_a, edge_b, running, mode_nz;
	logic        match_a, match_b;
	logic [15:0] capcomp_reg_a, capcomp_reg_b;
	tcc_pkg::reg_ctl_t ctl_a, ctl_b;

	// Match test on the count after the step; a zero compare hits on 0000H->0001H
	function automatic logic step_hits(input logic [15:0] cur, input logic [15:0] cmp);
		step_hits = (cmp == `TCC_CNT_ZERO) ? (cur == `TCC_CNT_ZERO)
			: (cur + `TCC_CNT_ONE == cmp);
	endfunction

	// Mode decode and edge detection; pin still driven one cycle after deselect
	assign mode_nz = {OP_MODE_BIT_HI, OP_MODE_BIT_LO} != `TCC_MODE_STOP;
	assign running = (st_q == tcc_pkg::ST_RUN) && mode_nz;
	assign ein_b_d = (PIN_SEL_OUTPUT || oe_q) ? 1'b0 : SHARED_PORT_PIN_IN;
	assign edge_a  = EDGE_INPUT_A && !ein_a_q && running;
	assign edge_b  = ein_b_d && !ein_b_q && running;
	// Match strobes, suppressed in capture mode
	assign match_a = COUNT_TICK && !CAPCOMP_A_CAPTURE &&
		step_hits(up_counter_q, capcomp_reg_a);
	assign match_b = COUNT_TICK && !CAPCOMP_B_CAPTURE &&
		step_hits(up_counter_q, capcomp_reg_b);

	// Register controls; capture only on pin edges, never on counter read
	always_comb begin
		ctl_a.cap_mode = CAPCOMP_A_CAPTURE;
		ctl_a.wr_en    = CAPCOMP_A_WR;
		ctl_a.wr_data  = CAPCOMP_A_WDATA;
		ctl_b.cap_mode = CAPCOMP_B_CAPTURE;
		ctl_b.wr_en    = CAPCOMP_B_WR;
		ctl_b.wr_data  = CAPCOMP_B_WDATA;
	end

	// Register a
	tcc_capreg u_reg_a (
		.clk      (SYS_CLK),
		.rst      (RESET),
		.ctl      (ctl_a),
		.cap_take (edge_a),
		.cnt      (up_counter_q),
		.rd_en    (CAPCOMP_A_RD),
		.value    (capcomp_reg_a),
		.rd_data  (CAPCOMP_A_RDATA)
	);

	// Register b; capture overrides read, no capture while stopped since edge_b needs running
	tcc_capreg u_reg_b (
		.clk      (SYS_CLK),
		.rst      (RESET),
		.ctl      (ctl_b),
		.cap_take (edge_b),
		.cnt      (up_counter_q),
		.rd_en    (CAPCOMP_B_RD),
		.value    (capcomp_reg_b),
		.rd_data  (CAPCOMP_B_RDATA)
	);

	// Counter, state, interrupts and pin output next values
	always_comb begin
		st_d         = st_q;
		up_counter_d = up_counter_q;
		cnt_rd_d     = cnt_rd_q;
		timer_out_d  = timer_out_q;
		irq_a_d      = 1'b0;
		irq_b_d      = 1'b0;
		oe_d         = PIN_SEL_OUTPUT;
		unique case (st_q)
			tcc_pkg::ST_STOP: begin
				up_counter_d = `TCC_CNT_ZERO;
				if (mode_nz) st_d = tcc_pkg::ST_RUN;
			end
			tcc_pkg::ST_RUN: begin
				if (!mode_nz) begin
					st_d = tcc_pkg::ST_HALT;
				end else if (COUNT_TICK) begin
					up_counter_d = up_counter_q + `TCC_CNT_ONE;
					irq_a_d = match_a;
					irq_b_d = match_b;
					if (match_a) timer_out_d = ~timer_out_q;
				end
			end
			tcc_pkg::ST_HALT: begin
				st_d = tcc_pkg::ST_STOP;
			end
			default: st_d = tcc_pkg::ST_STOP;
		endcase
		if (COUNTER_RD) cnt_rd_d = up_counter_q;
		pin_out_d = timer_out_d & PIN_SEL_OUTPUT;
	end

	// State registers
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			st_q         <= tcc_pkg::ST_STOP;
			up_counter_q <= `TCC_CNT_ZERO;
			cnt_rd_q     <= `TCC_CNT_ZERO;
			timer_out_q  <= 1'b0;
			irq_a_q      <= 1'b0;
			irq_b_q      <= 1'b0;
			oe_q         <= 1'b0;
			pin_out_q    <= 1'b0;
			ein_a_q      <= 1'b0;
			ein_b_q      <= 1'b0;
		end else begin
			st_q         <= st_d;
			up_counter_q <= up_counter_d;
			cnt_rd_q     <= cnt_rd_d;
			timer_out_q  <= timer_out_d;
			irq_a_q      <= irq_a_d;
			irq_b_q      <= irq_b_d;
			oe_q         <= oe_d;
			pin_out_q    <= pin_out_d;
			ein_a_q      <= EDGE_INPUT_A;
			ein_b_q      <= ein_b_d;
		end
	end

	// Outputs straight from flip-flops
	always_comb begin
		UP_COUNTER          = up_counter_q;
		COUNTER_RDATA       = cnt_rd_q;
		SHARED_PORT_PIN_OUT = pin_out_q;
		SHARED_PORT_PIN_OE  = oe_q;
		MATCH_IRQ_A         = irq_a_q;
		MATCH_IRQ_B         = irq_b_q;
	end

	// Checks
	a_pin_exclusive: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(PIN_SEL_OUTPUT || SHARED_PORT_PIN_OE) && !CAPCOMP_B_WR |=> $stable(capcomp_reg_b))
		else $error("pin drives while capturing");
	a_compare_nocap: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!CAPCOMP_B_CAPTURE && !CAPCOMP_B_WR |=> $stable(capcomp_reg_b))
		else $error("capture in compare mode");
	a_stop_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!running |=> $stable(UP_COUNTER) || UP_COUNTER == 16'h0000)
		else $error("counted while stopped");
	a_capture_wins: assert property (@(posedge SYS_CLK) disable iff (RESET)
		edge_b && CAPCOMP_B_CAPTURE |=> capcomp_reg_b == $past(up_counter_q))
		else $error("capture lost");
	a_zero_match: assert property (@(posedge SYS_CLK) disable iff (RESET)
		running && COUNT_TICK && !CAPCOMP_B_CAPTURE && capcomp_reg_b == 16'h0000
		&& up_counter_q == 16'h0000 |=> MATCH_IRQ_B && UP_COUNTER == 16'h0001)
		else $error("zero match missed");
	a_stop_quiet: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_q != tcc_pkg::ST_RUN |=> !MATCH_IRQ_A && !MATCH_IRQ_B)
		else $error("irq while stopped");
	a_start_run: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_q == tcc_pkg::ST_STOP && mode_nz |=> st_q == tcc_pkg::ST_RUN)
		else $error("counter did not start");
	a_count_step: assert property (@(posedge SYS_CLK) disable iff (RESET)
		running && COUNT_TICK |=> UP_COUNTER == $past(up_counter_q) + 16'h0001)
		else $error("bad counter step");
	a_irq_pulse: assert property (@(posedge SYS_CLK) disable iff (RESET)
		MATCH_IRQ_B |=> !MATCH_IRQ_B)
		else $error("irq longer than one tick");
	a_read_nocap: assert property (@(posedge SYS_CLK) disable iff (RESET)
		COUNTER_RD && !edge_b && !CAPCOMP_B_WR |=> $stable(capcomp_reg_b))
		else $error("read captured");
	c_match_b: cover property (@(posedge SYS_CLK) MATCH_IRQ_B);
	c_capture_b: cover property (@(posedge SYS_CLK) edge_b && CAPCOMP_B_CAPTURE);
	c_capture_rd: cover property (@(posedge SYS_CLK) edge_b && CAPCOMP_B_CAPTURE
		&& CAPCOMP_B_RD);
	c_wrap: cover property (@(posedge SYS_CLK) running && COUNT_TICK
		&& up_counter_q == 16'hFFFF);
endmodule
`default_nettype wire

/* verilog/tcc_cfg.svh */
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// Counter geometry and values
`define TCC_CNT_W      16
`define TCC_CNT_ZERO   16'h0000
`define TCC_CNT_ONE    16'h0001
`define TCC_CNT_MAX    16'hFFFF
// Mode field encodings (hi, lo)
`define TCC_MODE_STOP  2'h0
`define TCC_MODE_CLRIN 2'h1
`define TCC_MODE_CLRCM 2'h2
`define TCC_MODE_FREE  2'h3
// Reset values
`define TCC_REG_RST    16'h0000
// Capture-edge filter width in cycles
`define TCC_FILT_CYC   1
`endif

/* verilog/tcc_pkg.sv */
package tcc_pkg;
	// Per-register control group
	typedef struct packed {
		logic        cap_mode;
		logic        wr_en;
		logic [15:0] wr_data;
	} reg_ctl_t;
	// Counter operating state
	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_RUN  = 3'b010,
		ST_HALT = 3'b100
	} run_state_t;
endpackage

/* verilog/tcc_capreg.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tcc_cfg.svh"
// One capture/compare register with registered read data
module tcc_capreg (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Control
	input  wire tcc_pkg::reg_ctl_t     ctl,
	input  wire logic                  cap_take,
	input  wire logic [15:0]           cnt,
	input  wire logic                  rd_en,
	// Results
	output logic      [15:0]           value,
	output logic      [15:0]           rd_data
);
	logic [15:0] val_d;
	logic [15:0] rd_d;

	// Capture wins over write and read
	always_comb begin
		val_d = value;
		rd_d  = rd_data;
		if (ctl.cap_mode && cap_take) begin
			val_d = cnt;
			rd_d  = cnt;
		end else if (ctl.wr_en) begin
			val_d = ctl.wr_data;
		end else if (rd_en) begin
			rd_d = value;
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (rst) begin
			value   <= `TCC_REG_RST;
			rd_data <= `TCC_REG_RST;
		end else begin
			value   <= val_d;
			rd_data <= rd_d;
		end
	end
endmodule
`default_nettype wire

/* testbench/tcc_edge_source.sv */
`timescale 1ns/1ns
`default_nettype none
// Far side: edge sources and the wire of the shared pin
module tcc_edge_source (
	// Clock and commands
	input  wire logic clk,
	input  wire logic fire_a,
	input  wire logic fire_b,
	// Shared pin as driven by the timer
	input  wire logic pin_oe,
	input  wire logic pin_out,
	// Edges towards the timer
	output logic      edge_a,
	output logic      pin_in
);
	logic drv_b;
	// Edges launched just after a clock edge
	always @(posedge clk) begin
		edge_a <= fire_a;
		drv_b <= fire_b;
	end
	// Timer output wins the wire while enabled
	assign pin_in = pin_oe ? pin_out : drv_b;
endmodule
`default_nettype wire

/* testbench/timer_capture_compare_pair_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_pair_bench;
	// Stimulus and results
	logic clk = 0, rst = 1, m_lo = 0, m_hi = 0, tick = 0, cnt_rd = 0, sel_out = 0;
	logic cap_a = 0, cap_b = 0, wr_a = 0, wr_b = 0, rd_a = 0, rd_b = 0, fire_a = 0, fire_b = 0;
	logic [15:0] wd_a = 16'h0000, wd_b = 16'h0000, at;
	logic ia;
	wire logic edge_a, pin_in, pin_out, pin_oe, irq_a, irq_b;
	wire logic [15:0] cnt, cnt_rdata, rdata_a, rdata_b;
	int failures = 0, comparisons = 0;
	always #20 clk = ~clk;
	tcc_top dut (.SYS_CLK(clk), .RESET(rst), .OP_MODE_BIT_LO(m_lo), .OP_MODE_BIT_HI(m_hi),
		.COUNT_TICK(tick), .CAPCOMP_B_CAPTURE(cap_b), .CAPCOMP_B_WR(wr_b),
		.CAPCOMP_B_WDATA(wd_b), .CAPCOMP_B_RD(rd_b), .CAPCOMP_A_CAPTURE(cap_a),
		.CAPCOMP_A_WR(wr_a), .CAPCOMP_A_WDATA(wd_a), .CAPCOMP_A_RD(rd_a),
		.COUNTER_RD(cnt_rd), .EDGE_INPUT_A(edge_a), .SHARED_PORT_PIN_IN(pin_in),
		.PIN_SEL_OUTPUT(sel_out), .SHARED_PORT_PIN_OUT(pin_out), .SHARED_PORT_PIN_OE(pin_oe),
		.UP_COUNTER(cnt), .COUNTER_RDATA(cnt_rdata), .CAPCOMP_A_RDATA(rdata_a),
		.CAPCOMP_B_RDATA(rdata_b), .MATCH_IRQ_A(irq_a), .MATCH_IRQ_B(irq_b));
	tcc_edge_source far (.clk(clk), .fire_a(fire_a), .fire_b(fire_b), .pin_oe(pin_oe),
		.pin_out(pin_out), .edge_a(edge_a), .pin_in(pin_in));
	// Compare and report
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic mode(input logic [1:0] m);
		m_hi <= m[1];
		m_lo <= m[0];
		cyc(2);
	endtask
	// Run with ticks until match b, return count seen with it
	task automatic wait_b(input int lim);
		int k;
		tick <= 1;
		for (k = 0; k < lim; k++) begin
			@(posedge clk);
			if (irq_b === 1'b1) break;
		end
		at = (k < lim) ? cnt : 16'hxxxx;
		ia = irq_a;
		tick <= 0;
		cyc(1);
		check({15'h0000, irq_b}, 16'h0000);
	endtask
	// Both compare at 3, pin as timer output
	task automatic s_match();
		wr_a <= 1; wd_a <= 16'h0003; wr_b <= 1; wd_b <= 16'h0003; sel_out <= 1;
		cyc(1);
		wr_a <= 0; wr_b <= 0;
		mode(2'h3);
		wait_b(20);
		check(at, 16'h0003);
		check({15'h0000, ia}, 16'h0001);
		check({pin_oe, pin_out}, 16'h0003);
		cnt_rd <= 1;
		cyc(1);
		cnt_rd <= 0;
		cyc(1);
		check(cnt_rdata, 16'h0004);
	endtask
	// Captures at a held count, read colliding, then pin as output
	task automatic s_capture();
		cap_a <= 1; cap_b <= 1; sel_out <= 0; cnt_rd <= 1;
		cyc(2);
		cnt_rd <= 0;
		cyc(2);
		check(rdata_b, 16'h0000);
		fire_a <= 1; fire_b <= 1;
		cyc(1);
		rd_b <= 1; rd_a <= 1;
		cyc(1);
		rd_b <= 0; rd_a <= 0; fire_a <= 0; fire_b <= 0;
		cyc(3);
		check(rdata_b, 16'h0004);
		check(rdata_a, 16'h0004);
		sel_out <= 1; tick <= 1;
		cyc(2);
		tick <= 0; fire_b <= 1;
		cyc(3);
		fire_b <= 0;
		check(rdata_b, 16'h0004);
	endtask
	// Zero compare written below count: match only after wrap
	task automatic s_wrap();
		cap_b <= 0; wr_b <= 1; wd_b <= 16'h0000;
		cyc(1);
		wr_b <= 0;
		wait_b(70000);
		check(at, 16'h0001);
		check({15'h0000, ia}, 16'h0000);
	endtask
	// Stopped timer ignores ticks and edges
	task automatic s_stop();
		logic [15:0] seen_irq;
		mode(2'h0);
		tick <= 1; fire_a <= 1; fire_b <= 1; sel_out <= 0; seen_irq = 16'h0000;
		repeat (6) begin
			@(posedge clk);
			seen_irq = seen_irq | {14'h0000, irq_a, irq_b};
		end
		tick <= 0;
		cyc(1);
		check(cnt, 16'h0000);
		check(seen_irq, 16'h0000);
	endtask
	task automatic close_out();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(2);
		rst <= 0;
		cyc(1);
		s_match();
		s_capture();
		s_wrap();
		s_stop();
		close_out();
	end
	// Watchdog
	initial begin
		cyc(80000);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
